/* hw/in_ep_ctrl_low.sv */
// IN endpoint low control and status logic for endpoints 1 to 3.
// Assumes an AHB-Lite master and a serial engine that delivers one-cycle token events.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
module in_ep_ctrl_low
  import in_ep_pkg::*;
#(
  parameter int EP_COUNT = 3
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire link_evt_t   evt,
  output link_ans_t        ans,
  output logic      [EP_COUNT:1] ep_event
);
  typedef logic [7:0] byte_t;

  // Registers per endpoint and bus state.
  byte_t      low_q   [EP_COUNT:1], low_d   [EP_COUNT:1];
  byte_t      high_q  [EP_COUNT:1], high_d  [EP_COUNT:1];
  logic [1:0] slots_q [EP_COUNT:1], slots_d [EP_COUNT:1];
  logic       tog_q   [EP_COUNT:1], tog_d   [EP_COUNT:1];
  logic       hold_q  [EP_COUNT:1], hold_d  [EP_COUNT:1];
  logic [1:0] index_q, index_d;
  logic       wr_q, wr_d, rd_q, rd_d;
  logic [9:0] addr_q, addr_d;
  logic [31:0] hrdata_d;
  link_ans_t  ans_d;
  logic [EP_COUNT:1] ep_event_d;

  // Number of packet slots an endpoint offers: two with double buffering, else one.
  function automatic logic [1:0] slot_cap(input byte_t h);
    return h[B_DBUF] ? SLOTS_MAX : 2'h1;
  endfunction

  // Readback of the low register: bit 7 and clear_toggle always zero.
  function automatic byte_t low_view(input byte_t r, input logic hold, input logic full);
    byte_t v;
    v = r;
    v[7] = 1'b0;
    v[B_CLRTOG] = 1'b0;
    // Packet-ready reads one while a packet not held for the next frame waits for a slot, or while every slot is taken.
    v[B_PRDY] = (r[B_PRDY] && !hold) || full;
    return v;
  endfunction

  // Address phase capture.
  always_comb begin
    wr_d   = 1'b0;
    rd_d   = 1'b0;
    addr_d = addr_q;
    if (hsel && hready && htrans[1]) begin
      wr_d   = hwrite;
      rd_d   = !hwrite;
      addr_d = haddr[9:0];
    end
  end

  // Register and endpoint next state; stall and underrun flag sets win over firmware clears, clear_toggle wins over an ACK toggle.
  always_comb begin
    logic  wsel;
    byte_t w;
    logic  ready;
    wsel = 1'b0;
    w = hwdata[7:0];
    ready = 1'b0;
    index_d = index_q;
    ans_d = '{answer: ANS_NONE, zero_len: 1'b0, toggle: 1'b0};
    ep_event_d = '0;
    hrdata_d = '0;
    for (int e = 1; e <= EP_COUNT; e++) begin
      low_d[e]   = low_q[e];
      high_d[e]  = high_q[e];
      slots_d[e] = slots_q[e];
      tog_d[e]   = tog_q[e];
      hold_d[e]  = hold_q[e];
    end
    if (wr_q && addr_q == INDEX_ADDR) begin
      index_d = hwdata[1:0];
    end
    for (int e = 1; e <= EP_COUNT; e++) begin
      wsel = wr_q && (index_q == 2'(e));
      if (wsel && addr_q == CTRL_HIGH_ADDR) begin
        high_d[e] = w;
      end
      if (wsel && addr_q == CTRL_LOW_ADDR) begin
        if (w[B_CLRTOG]) begin
          tog_d[e] = 1'b0;
        end
        low_d[e][B_STREQ] = w[B_STREQ];
        if (!w[B_STSENT]) begin
          low_d[e][B_STSENT] = 1'b0;
        end
        if (!w[B_UNDER]) begin
          low_d[e][B_UNDER] = 1'b0;
        end
        if (w[B_FLUSH] && slots_q[e] != 2'h0) begin
          slots_d[e] = slots_q[e] - 2'h1;
          ep_event_d[e] = 1'b1;
        end
        if (w[B_PRDY] && !low_q[e][B_PRDY]) begin
          low_d[e][B_PRDY] = 1'b1;
          hold_d[e] = high_q[e][B_ISO] && high_q[e][B_ISO_UPDATE_ENABLE];
        end
      end
      if (evt.sof) begin
        hold_d[e] = 1'b0;
      end
      // A pending packet-ready moves into a free slot; the readback also shows ready while all slots are full.
      if (low_q[e][B_PRDY] && !hold_q[e] && slots_q[e] < slot_cap(high_q[e])) begin
        slots_d[e] = slots_d[e] + 2'h1;
        low_d[e][B_PRDY] = 1'b0;
      end
      ready = slots_q[e] != 2'h0;
      if (evt.in_tok && evt.ep == 2'(e)) begin
        if (low_q[e][B_STREQ]) begin
          ans_d.answer = ANS_STALL;
          low_d[e][B_STSENT] = 1'b1;
          ep_event_d[e] = 1'b1;
        end else if (ready) begin
          ans_d.answer = ANS_DATA;
          ans_d.toggle = tog_q[e];
          slots_d[e] = slots_d[e] - 2'h1;
          ep_event_d[e] = 1'b1;
        end else if (high_q[e][B_ISO]) begin
          ans_d.answer = ANS_DATA;
          ans_d.zero_len = 1'b1;
          ans_d.toggle = tog_q[e];
          low_d[e][B_UNDER] = 1'b1;
        end else begin
          ans_d.answer = ANS_NAK;
          low_d[e][B_UNDER] = 1'b1;
        end
      end
      if (evt.acked && evt.ep == 2'(e)) begin
        tog_d[e] = !tog_q[e];
      end
      if (wsel && addr_q == CTRL_LOW_ADDR && w[B_CLRTOG]) begin
        tog_d[e] = 1'b0;
      end
      low_d[e][7] = 1'b0;
      low_d[e][B_CLRTOG] = 1'b0;
      low_d[e][B_FLUSH] = 1'b0;
      low_d[e][B_NEMPTY] = slots_d[e] != 2'h0;
    end
    // Read data for the selected endpoint.
    for (int e = 1; e <= EP_COUNT; e++) begin
      if (rd_d && index_q == 2'(e)) begin
        if (addr_d == CTRL_LOW_ADDR) begin
          hrdata_d = {24'h0, low_view(low_q[e], hold_q[e], slots_q[e] >= slot_cap(high_q[e]))};
        end else if (addr_d == CTRL_HIGH_ADDR) begin
          hrdata_d = {24'h0, high_q[e]};
        end
      end
    end
    if (rd_d && addr_d == INDEX_ADDR) begin
      hrdata_d = {30'h0, index_q};
    end
  end

  // State registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int e = 1; e <= EP_COUNT; e++) begin
        low_q[e]   <= LOW_RESET;
        high_q[e]  <= HIGH_RESET;
        slots_q[e] <= 2'h0;
        tog_q[e]   <= 1'b0;
        hold_q[e]  <= 1'b0;
      end
      index_q   <= EP_FIRST;
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      addr_q    <= 10'h000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      ans       <= '{answer: ANS_NONE, zero_len: 1'b0, toggle: 1'b0};
      ep_event  <= '0;
    end else begin
      for (int e = 1; e <= EP_COUNT; e++) begin
        low_q[e]   <= low_d[e];
        high_q[e]  <= high_d[e];
        slots_q[e] <= slots_d[e];
        tog_q[e]   <= tog_d[e];
        hold_q[e]  <= hold_d[e];
      end
      index_q   <= index_d;
      wr_q      <= wr_d;
      rd_q      <= rd_d;
      addr_q    <= addr_d;
      hrdata    <= hrdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      ans       <= ans_d;
      ep_event  <= ep_event_d;
    end
  end

  // Endpoint-independent checks on the answer and on the bus readback.
  a_stall_event: assert property (@(posedge hclk) disable iff (!hresetn)
    (ans.answer == ANS_STALL) |-> (ep_event != '0))
    else $error("stall without endpoint event");
  a_zero_data: assert property (@(posedge hclk) disable iff (!hresetn)
    ans.zero_len |-> (ans.answer == ANS_DATA))
    else $error("zero length flag without a data answer");
  a_read_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_q && addr_q == CTRL_LOW_ADDR) |-> (hrdata[7] == 1'b0 && hrdata[B_CLRTOG] == 1'b0))
    else $error("unused or clear_toggle bit read as one");

  // Per-endpoint checks, one set for every endpoint; the bench drives only the one endpoint it picks at random.
  for (genvar g = 1; g <= EP_COUNT; g++) begin : g_chk
    // A token on a stalled endpoint is answered with STALL and sets stall_sent_flag.
    a_stall_answer: assert property (@(posedge hclk) disable iff (!hresetn)
      (evt.in_tok && evt.ep == 2'(g) && low_q[g][B_STREQ]) |=> (ans.answer == ANS_STALL && low_q[g][B_STSENT]))
      else $error("stall request not answered with stall");

    // Once the stall request is withdrawn no token is answered with STALL.
    a_stall_resume: assert property (@(posedge hclk) disable iff (!hresetn)
      (evt.in_tok && evt.ep == 2'(g) && !low_q[g][B_STREQ]) |=> (ans.answer != ANS_STALL))
      else $error("stall sent without a stall request");

    // A bulk or interrupt token on an empty FIFO gets NAK and flags underrun.
    a_nak_underrun: assert property (@(posedge hclk) disable iff (!hresetn)
      (evt.in_tok && evt.ep == 2'(g) && !low_q[g][B_STREQ] && slots_q[g] == 2'h0 && !high_q[g][B_ISO])
      |=> (ans.answer == ANS_NAK && low_q[g][B_UNDER]))
      else $error("empty bulk endpoint did not nak with underrun");

    // An isochronous token on an empty FIFO gets a zero-length packet and flags underrun.
    a_iso_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      (evt.in_tok && evt.ep == 2'(g) && !low_q[g][B_STREQ] && slots_q[g] == 2'h0 && high_q[g][B_ISO])
      |=> (ans.zero_len && low_q[g][B_UNDER]))
      else $error("iso underrun did not send zero length");

    // A queued packet goes out as data and raises the endpoint event.
    a_data_send: assert property (@(posedge hclk) disable iff (!hresetn)
      (evt.in_tok && evt.ep == 2'(g) && !low_q[g][B_STREQ] && slots_q[g] != 2'h0)
      |=> (ans.answer == ANS_DATA && !ans.zero_len && ep_event[g]))
      else $error("queued packet not sent with an event");

    // The FIFO-not-empty bit follows the packet count.
    a_not_empty: assert property (@(posedge hclk) disable iff (!hresetn)
      low_q[g][B_NEMPTY] == (slots_q[g] != 2'h0))
      else $error("fifo_not_empty disagrees with fill");

    // The stall and underrun flags hold until firmware writes the low register.
    a_sent_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      (low_q[g][B_STSENT] && !(wr_q && addr_q == CTRL_LOW_ADDR)) |=> low_q[g][B_STSENT])
      else $error("stall_sent_flag dropped without a write");
    a_underrun_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      (low_q[g][B_UNDER] && !(wr_q && addr_q == CTRL_LOW_ADDR)) |=> low_q[g][B_UNDER])
      else $error("underrun_flag dropped without a write");

    // Writing zero to stall_sent_flag clears it unless a stall goes out in the same cycle.
    a_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_q && index_q == 2'(g) && addr_q == CTRL_LOW_ADDR && !hwdata[B_STSENT] && !(evt.in_tok && evt.ep == 2'(g)))
      |=> !low_q[g][B_STSENT])
      else $error("stall_sent_flag not cleared by firmware");

    // Writing clear_toggle leaves the data toggle at zero.
    a_toggle_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_q && index_q == 2'(g) && addr_q == CTRL_LOW_ADDR && hwdata[B_CLRTOG]) |=> !tog_q[g])
      else $error("data toggle not cleared");

    // Each flush of a non-empty FIFO drops one packet and raises the endpoint event.
    a_flush_drop: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_q && index_q == 2'(g) && addr_q == CTRL_LOW_ADDR && hwdata[B_FLUSH] && slots_q[g] != 2'h0
       && !low_q[g][B_PRDY] && !(evt.in_tok && evt.ep == 2'(g)))
      |=> (slots_q[g] == $past(slots_q[g]) - 2'h1 && ep_event[g]))
      else $error("flush did not drop exactly one packet");

    // A pending packet-ready that is not held, with a free slot, is queued on the next cycle.
    a_pending_promote: assert property (@(posedge hclk) disable iff (!hresetn)
      (low_q[g][B_PRDY] && !hold_q[g] && slots_q[g] < slot_cap(high_q[g]) && !wr_q)
      |=> (!low_q[g][B_PRDY] && slots_q[g] != 2'h0))
      else $error("pending packet not queued into a free slot");

    // A packet held for the next frame is not queued before start-of-frame.
    a_held_no_move: assert property (@(posedge hclk) disable iff (!hresetn)
      (hold_q[g] && low_q[g][B_PRDY] && !(evt.in_tok && evt.ep == 2'(g)) && !wr_q)
      |=> (slots_q[g] == $past(slots_q[g])))
      else $error("held packet queued before start of frame");
  end
endmodule

/* hw/in_ep_pkg.sv */
// Package for the IN endpoint low control and status block.
// Assumes an AHB-Lite slave with 32-bit data and one word per register.
package in_ep_pkg;
  // Printed offsets are not multiples of four, so they are register indices.
  localparam logic [7:0]  CTRL_LOW_IDX   = 8'h11;
  localparam logic [7:0]  CTRL_HIGH_IDX  = 8'h12;
  localparam logic [7:0]  INDEX_IDX      = 8'h0e;
  localparam logic [7:0]  STATUS_IDX     = 8'h20;
  localparam logic [9:0]  CTRL_LOW_ADDR  = {CTRL_LOW_IDX, 2'b00};
  localparam logic [9:0]  CTRL_HIGH_ADDR = {CTRL_HIGH_IDX, 2'b00};
  localparam logic [9:0]  INDEX_ADDR     = {INDEX_IDX, 2'b00};
  localparam logic [9:0]  STATUS_ADDR    = {STATUS_IDX, 2'b00};
  // Field positions in the low control register.
  localparam int B_CLRTOG = 6;
  localparam int B_STSENT = 5;
  localparam int B_STREQ  = 4;
  localparam int B_FLUSH  = 3;
  localparam int B_UNDER  = 2;
  localparam int B_NEMPTY = 1;
  localparam int B_PRDY   = 0;
  // Field positions in the high control register.
  localparam int B_DBUF   = 7;
  localparam int B_ISO    = 6;
  localparam int B_ISO_UPDATE_ENABLE  = 5;
  localparam logic [7:0] LOW_RESET  = 8'h00;
  localparam logic [7:0] HIGH_RESET = 8'h00;
  localparam logic [1:0] EP_FIRST   = 2'h1;
  localparam logic [1:0] SLOTS_MAX  = 2'h2;
  // Handshake answer to an IN token.
  typedef enum logic [1:0] {ANS_NONE, ANS_DATA, ANS_NAK, ANS_STALL} answer_t;
  // Token request from the serial engine.
  typedef struct packed {
    logic       in_tok;
    logic [1:0] ep;
    logic       sof;
    logic       acked;
    logic       load;
  } link_evt_t;
  // Answer to the serial engine.
  typedef struct packed {
    answer_t answer;
    logic    zero_len;
    logic    toggle;
  } link_ans_t;
endpackage

/* test/testbench.sv */
// Self-checking bench for the IN endpoint low control block.
// Assumes usb_host_model on the link side; the bench is the AHB-Lite master.
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
  import in_ep_pkg::*;
  logic        hclk;
  logic        hresetn  = 1'b0;
  logic        hsel     = 1'b0;
  logic        hwrite   = 1'b0;
  logic [1:0]  htrans   = 2'b00;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] haddr    = '0;
  logic [31:0] hwdata   = '0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  link_evt_t   evt;
  link_ans_t   ans;
  logic [3:1]  ep_event;
  logic [1:0]  e        = 2'h1;
  logic [31:0] r;
  int          bad_count, n_tests, ev_n, n0;
  int          seed     = 14667;
  int          slots    = 1;
  int          pk[$];

  in_ep_ctrl_low #(.EP_COUNT(3)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .evt(evt), .ans(ans), .ep_event(ep_event));
  usb_host_model host (.hclk(hclk), .ans(ans), .evt(evt));

  // Free-running clock and a count of event pulses on the chosen endpoint.
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) if (ep_event[e] === 1'b1) ev_n++;

  // One single-word transfer; read data is taken at the data-phase edge.
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {22'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // Reads a register and compares the masked low byte.
  task automatic rd(input logic [9:0] a, input logic [7:0] m, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    `CHK("register", x, r[7:0] & m)
  endtask

  // Sends a token and compares the answer kind and length.
  task automatic tk(input logic ack, input answer_t a, input logic z);
    n0 = ev_n;
    host.token(e, ack);
    `CHK("answer", a, host.got.answer)
    `CHK("zero_len", z, host.got.zero_len)
  endtask

  // Prints the verdict and ends the run.
  task automatic end_sim();
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #300000;
    bad_count++;
    end_sim();
  end

  // Main sequence on one randomly chosen endpoint.
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    e = 2'(1 + ($unsigned($random(seed)) % 3));
    rd(CTRL_LOW_ADDR, 8'hff, LOW_RESET);
    rd(CTRL_HIGH_ADDR, 8'hff, HIGH_RESET);
    rd(10'h3fc, 8'hff, 8'h00);
    bus(1'b1, INDEX_ADDR, {6'h00, e});
    bus(1'b1, CTRL_LOW_ADDR, 8'hc0);
    rd(CTRL_LOW_ADDR, 8'hff, 8'h00);
    bus(1'b1, CTRL_LOW_ADDR, 8'h10);
    tk(1'b1, ANS_STALL, 1'b0);
    `CHK("event", n0 + 1, ev_n)
    rd(CTRL_LOW_ADDR, 8'h30, 8'h30);
    bus(1'b1, CTRL_LOW_ADDR, 8'h00);
    rd(CTRL_LOW_ADDR, 8'h20, 8'h00);
    tk(1'b1, ANS_NAK, 1'b0);
    rd(CTRL_LOW_ADDR, 8'h04, 8'h04);
    // A packet goes out with toggle zero, then the toggle is cleared again.
    bus(1'b1, CTRL_LOW_ADDR, 8'h01);
    pk.push_back(1);
    rd(CTRL_LOW_ADDR, 8'h03, {6'h00, pk.size() > 0, pk.size() >= slots});
    tk(1'b1, ANS_DATA, 1'b0);
    `CHK("toggle", 1'b0, host.got.toggle)
    `CHK("event", n0 + 1, ev_n)
    void'(pk.pop_front());
    rd(CTRL_LOW_ADDR, 8'h03, {6'h00, pk.size() > 0, 1'b0});
    bus(1'b1, CTRL_LOW_ADDR, 8'h40);
    bus(1'b1, CTRL_LOW_ADDR, 8'h01);
    tk(1'b1, ANS_DATA, 1'b0);
    `CHK("toggle", 1'b0, host.got.toggle)
    // Two packets queued with double buffering, then flushed one by one.
    bus(1'b1, CTRL_HIGH_ADDR, 8'h80);
    slots = 2;
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, CTRL_LOW_ADDR, 8'h01);
      pk.push_back(i);
      rd(CTRL_LOW_ADDR, 8'h03, {6'h00, 1'b1, pk.size() >= slots});
    end
    for (int i = 0; i < 3; i++) begin
      n0 = ev_n + int'(pk.size() > 0);
      bus(1'b1, CTRL_LOW_ADDR, 8'h08);
      if (pk.size() > 0) void'(pk.pop_front());
      rd(CTRL_LOW_ADDR, 8'h02, {6'h00, pk.size() > 0, 1'b0});
      `CHK("event", n0, ev_n)
    end
    // Isochronous underrun, then a packet held back until the next frame.
    bus(1'b1, CTRL_HIGH_ADDR, 8'h40);
    bus(1'b1, CTRL_LOW_ADDR, 8'h00);
    tk(1'b0, ANS_DATA, 1'b1);
    rd(CTRL_LOW_ADDR, 8'h04, 8'h04);
    bus(1'b1, CTRL_HIGH_ADDR, 8'h60);
    bus(1'b1, CTRL_LOW_ADDR, 8'h01);
    rd(CTRL_LOW_ADDR, 8'h01, 8'h00);
    host.frame();
    tk(1'b0, ANS_DATA, 1'b0);
    end_sim();
  end
endmodule

/* test/usb_host_model.sv */
// Host side model: issues IN tokens, start-of-frame marks and ACKs.
// Assumes the design samples evt on the rising edge of hclk.
`timescale 1ns/10ps
module usb_host_model
  import in_ep_pkg::*;
(
  input  wire logic      hclk,
  input  wire link_ans_t ans,
  output link_evt_t      evt
);
  link_ans_t got;

  // The link is quiet until the bench asks for traffic.
  initial evt = '0;

  // Sends one token, keeps the answer and acknowledges data when asked.
  task automatic token(input logic [1:0] e, input logic ack);
    @(posedge hclk);
    evt.in_tok <= 1'b1;
    evt.ep     <= e;
    @(posedge hclk);
    evt.in_tok <= 1'b0;
    evt.ep     <= ~e; // A released field does not keep its value.
    got = '0;
    repeat (4) begin
      @(posedge hclk);
      if (ans.answer !== ANS_NONE) got = ans;
    end
    if (ack && got.answer === ANS_DATA) begin
      @(posedge hclk);
      evt.acked <= 1'b1;
      evt.ep    <= e;
      @(posedge hclk);
      evt.acked <= 1'b0;
    end
  endtask

  // Marks the start of a frame for one cycle.
  task automatic frame();
    @(posedge hclk);
    evt.sof <= 1'b1;
    @(posedge hclk);
    evt.sof <= 1'b0;
  endtask
endmodule
